/* File: bench/isp_master_model.sv */
`timescale 1ns/1ps

module isp_master_model (
   input  wire logic i_ref_clk,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda
);
   // bus idles high through the pull-up; clock stands still between frames
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end

   task automatic wt(input int n);
      repeat (n) @(posedge i_ref_clk);
   endtask

   // start or repeated start, data falls while clock high
   task automatic start();
      o_sda <= 1'b1;
      wt(4);
      o_scl <= 1'b1;
      wt(6);
      o_sda <= 1'b0;
      wt(6);
      o_scl <= 1'b0;
      wt(1);
   endtask

   // data rises while clock high
   task automatic stop();
      o_sda <= 1'b0;
      wt(4);
      o_scl <= 1'b1;
      wt(6);
      o_sda <= 1'b1;
      wt(6);
   endtask

   // master makes every clock; data set while low, held while high
   task automatic bit_x(input logic b, output logic got);
      wt(3);
      o_sda <= b;
      wt(5);
      o_scl <= 1'b1;
      wt(4);
      got = i_sda;
      wt(4);
      o_scl <= 1'b0;
   endtask

   // msb first, then release for the acknowledge clock
   task automatic put(input logic [7:0] b, output logic ack);
      logic g;
      for (int i = 7; i >= 0; i--)
         bit_x(b[i], g);
      bit_x(1'b1, ack);
   endtask

   // keep sda released while reading; nack the last byte
   task automatic get(input logic last, output logic [7:0] b);
      logic g;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, g);
         b[i] = g;
      end
      bit_x(last, g);
   endtask
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/1ps

module tb_top;
   import isp_pkg::*;

   localparam logic [7:0] DEV_W = {DEV_TYPE, 3'h5, 1'b0};
   localparam logic [7:0] DEV_R = {DEV_TYPE, 3'h5, 1'b1};

   logic              i_ref_clk;
   logic              i_srst;
   logic [2:0]        pins;
   logic              wp;
   logic              scl;
   logic              m_sda;
   wire               sda_w;
   logic              o_sda;
   logic              oe_n;
   logic              hs;
   logic              busy;
   int                mismatches = 0;
   int                n_checks = 0;
   int                cyc = 0;

   assign sda_w = m_sda & (oe_n | o_sda);

   isp_mem_slave isp_mem_slave_i (
      .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_scl(scl), .i_sda(sda_w),
      .o_sda(o_sda), .o_sda_oe_n(oe_n), .i_device_select_pins(pins),
      .i_write_protect(wp), .o_hs_mode(hs), .o_busy(busy));

   isp_master_model isp_master_model_i (
      .i_ref_clk(i_ref_clk), .i_sda(sda_w), .o_scl(scl), .o_sda(m_sda));

   initial begin
      i_ref_clk = 1'b0;
      forever #12.5 i_ref_clk = ~i_ref_clk;
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   always @(posedge i_ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         mismatches++;
         complete_run();
      end
   end

   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic send(input logic [7:0] b, input logic exp_ack);
      logic a;
      isp_master_model_i.put(b, a);
      chk(a, exp_ack);
   endtask

   task automatic set_addr(input logic [15:0] a);
      isp_master_model_i.start();
      send(DEV_W, 1'b0);
      send(a[15:8], 1'b0);
      send(a[7:0], 1'b0);
   endtask

   task automatic rd_chk(input logic [7:0] exp, input logic last);
      logic [7:0] b;
      isp_master_model_i.get(last, b);
      chk(b, exp);
   endtask

   task automatic t_wrap();
      set_addr(16'hFFFE);
      chk(busy, 1'b1);
      send(8'h3C, 1'b0);
      send(8'hC3, 1'b0);
      send(8'h5A, 1'b0);
      isp_master_model_i.stop();
      set_addr(16'hFFFE);
      isp_master_model_i.start();
      send(DEV_R, 1'b0);
      rd_chk(8'h3C, 1'b0);
      rd_chk(8'hC3, 1'b0);
      rd_chk(8'h5A, 1'b1);
      chk(oe_n, 1'b1);
      chk(busy, 1'b0);
      isp_master_model_i.stop();
      $display("test wrap done");
   endtask

   task automatic t_select();
      for (int s = 0; s < 8; s++) begin
         isp_master_model_i.start();
         send({DEV_TYPE, 3'(s), 1'b0}, s != 5);
         isp_master_model_i.stop();
      end
      isp_master_model_i.start();
      send({4'hB, 3'h5, 1'b0}, 1'b1);
      isp_master_model_i.stop();
      // move the select pins so the match follows them, not a constant
      pins <= 3'h2;
      isp_master_model_i.start();
      send({DEV_TYPE, 3'h2, 1'b0}, 1'b0);
      isp_master_model_i.stop();
      isp_master_model_i.start();
      send({DEV_TYPE, 3'h5, 1'b0}, 1'b1);
      isp_master_model_i.stop();
      pins <= 3'h5;
      isp_master_model_i.wt(2);
      chk(busy, 1'b0);
      $display("test select done");
   endtask

   task automatic t_hs();
      isp_master_model_i.start();
      send({HS_CODE, 3'h6}, 1'b1);
      chk(hs, 1'b1);
      set_addr(16'h0040);
      send(8'h96, 1'b0);
      chk(hs, 1'b1);
      isp_master_model_i.stop();
      isp_master_model_i.wt(2);
      chk(hs, 1'b0);
      $display("test high speed done");
   endtask

   task automatic t_wp();
      set_addr(16'h0010);
      send(8'h11, 1'b0);
      isp_master_model_i.stop();
      wp <= 1'b1;
      set_addr(16'h0010);
      send(8'h55, 1'b1);
      isp_master_model_i.start();
      send(DEV_R, 1'b0);
      rd_chk(8'h11, 1'b1);
      isp_master_model_i.stop();
      wp <= 1'b0;
      $display("test protect done");
   endtask

   task automatic t_abort();
      logic g;
      set_addr(16'h0020);
      send(8'hA5, 1'b0);
      set_addr(16'h0020);
      for (int i = 7; i > 2; i--)
         isp_master_model_i.bit_x(i[0], g);
      isp_master_model_i.stop();
      isp_master_model_i.wt(2);
      chk(busy, 1'b0);
      isp_master_model_i.start();
      send(DEV_R, 1'b0);
      rd_chk(8'hA5, 1'b1);
      isp_master_model_i.stop();
      $display("test abort done");
   endtask

   // a burst of eight bytes runs through the internal write queue
   task automatic t_burst();
      set_addr(16'h0100);
      for (int k = 0; k < 8; k++)
         send(8'(8'h10 + k), 1'b0);
      isp_master_model_i.stop();
      set_addr(16'h0100);
      isp_master_model_i.start();
      send(DEV_R, 1'b0);
      for (int k = 0; k < 8; k++)
         rd_chk(8'(8'h10 + k), k == 7);
      chk(oe_n, 1'b1);
      chk(busy, 1'b0);
      isp_master_model_i.stop();
      $display("test burst done");
   endtask

   initial begin
      i_srst = 1'b1;
      pins = 3'h5;
      wp = 1'b0;
      repeat (3) @(posedge i_ref_clk);
      i_srst <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      chk(oe_n, 1'b1);
      chk(hs, 1'b0);
      chk(busy, 1'b0);
      chk(o_sda, 1'b0);
      t_wrap();
      t_select();
      t_hs();
      t_wp();
      t_abort();
      t_burst();
      complete_run();
   end
endmodule

/* File: hdl/isp_mem_slave.sv */
// How it works
// - 64K bytes, 16-bit address, serial byte transfer
// - writes complete within the bus transfer
// - slave only; master drives the clock
// - data rising while clock high is stop
// - stop abandons the operation in progress
// - data falling while clock high is start
// - data stable while clock high; sample there
// - ninth clock is acknowledge, receiver pulls low
// - missing acknowledge ends the operation
// - first byte after start is slave address
// - upper nibble must equal device type 1010
// - bits three to one match select pins
// - lowest address bit: one read, zero write
// - master code 00001xxx enters high speed mode
// - stop leaves high speed mode
// - write carries two address bytes into latch
// - address latch held; reads start there
// - address increments just before acknowledge slot
// - address wraps to zero; unlimited bytes
// - read: send byte, acknowledged means continue
// - most significant bit first; written bytes acknowledged
// - drive on falling edge, capture on rising
// - byte committed at 8th bit, before acknowledge
// - write protect: no acknowledge, no increment
`timescale 1ns/1ps

module isp_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 8
) (
   input  wire logic             i_ref_clk,
   input  wire logic             i_srst,
   input  wire logic             i_valid,
   output logic                  o_ready,
   input  wire logic [WIDTH-1:0] i_data,
   output logic                  o_valid,
   input  wire logic             i_ready,
   output logic      [WIDTH-1:0] o_data
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] store [DEPTH];
   logic [PW-1:0]    wr_ptr;
   logic [PW-1:0]    rd_ptr;
   logic [PW:0]      count;
   logic [PW-1:0]    next_wr_ptr;
   logic [PW-1:0]    next_rd_ptr;
   logic [PW:0]      next_count;
   logic             do_push;
   logic             do_pop;

   assign o_ready = (count != (PW+1)'(DEPTH));
   assign o_valid = (count != '0);
   assign o_data  = store[rd_ptr];
   assign do_push = i_valid & o_ready;
   assign do_pop  = o_valid & i_ready;

   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count  = count;
      if (do_push) begin
         next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
         next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (do_push && !do_pop) begin
         next_count = count + 1'b1;
      end else if (do_pop && !do_push) begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
      if (do_push) begin
         store[wr_ptr] <= i_data;
      end
   end
endmodule

module isp_mem_slave (
   input  wire logic       i_ref_clk,
   input  wire logic       i_srst,
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   output logic            o_sda,
   output logic            o_sda_oe_n,
   input  wire logic [2:0] i_device_select_pins,
   input  wire logic       i_write_protect,
   output logic            o_hs_mode,
   output logic            o_busy
);
   import isp_pkg::*;

   // the array itself: one byte per 16-bit address
   logic [DATA_W-1:0] mem [MEM_WORDS];

   isp_state_e        state;
   isp_state_e        next_state;
   isp_state_e        after;
   isp_state_e        next_after;
   isp_kind_e         kind;
   isp_kind_e         next_kind;
   logic              scl_q;
   logic              sda_q;
   logic [2:0]        cnt;
   logic [2:0]        next_cnt;
   logic [7:0]        sh;
   logic [7:0]        next_sh;
   logic [7:0]        addr_hi;
   logic [7:0]        next_addr_hi;
   logic [15:0]       addr;
   logic [15:0]       next_addr;
   logic              hs;
   logic              next_hs;
   logic              ack_on;
   logic              next_ack_on;
   logic              oe_n;
   logic              next_oe_n;
   logic [7:0]        rd_byte;
   logic              rd_req;
   logic              push;
   logic              addr_inc;
   logic              scl_rise;
   logic              scl_fall;
   logic              start_c;
   logic              stop_c;
   logic              dev_hit;
   logic [7:0]        byte_in;
   logic              fifo_in_ready;
   logic              drain_valid;
   logic              drain_ready;
   logic [FIFO_W-1:0] drain_data;

   // clock edges, and the bus conditions seen while the clock is high
   assign scl_rise = i_scl & ~scl_q;
   assign scl_fall = ~i_scl & scl_q;
   assign start_c  = i_scl & scl_q & sda_q & ~i_sda;
   assign stop_c   = i_scl & scl_q & ~sda_q & i_sda;
   assign byte_in  = {sh[6:0], i_sda};
   assign dev_hit  = (byte_in[7:4] == DEV_TYPE) &&
                     (byte_in[3:1] == i_device_select_pins);

   // only pulls low; the clock is never driven
   assign o_sda      = 1'b0;
   assign o_sda_oe_n = oe_n;
   assign o_hs_mode  = hs;
   assign o_busy     = (state != S_IDLE);

   always_comb begin
      next_state   = state;
      next_after   = after;
      next_kind    = kind;
      next_cnt     = cnt;
      next_sh      = sh;
      next_addr_hi = addr_hi;
      next_addr    = addr;
      next_hs      = hs;
      next_ack_on  = ack_on;
      next_oe_n    = oe_n;
      rd_req       = 1'b0;
      push         = 1'b0;
      addr_inc     = 1'b0;
      case (state)
         S_IDLE: begin
         end
         S_RECV: begin
            if (scl_rise) begin
               next_sh    = byte_in;
               next_cnt   = cnt + 3'h1;
               next_after = S_RECV;
               if (cnt == LAST_BIT) begin
                  next_cnt   = '0;
                  next_state = S_SACK;
                  case (kind)
                     K_DEV: begin
                        if (byte_in[7:3] == HS_CODE) begin
                           next_hs    = 1'b1;
                           next_state = S_IDLE;
                        end else if (dev_hit) begin
                           next_kind = K_AHI;
                           if (byte_in[0]) begin
                              rd_req     = 1'b1;
                              next_after = S_SEND;
                           end
                        end else begin
                           next_state = S_IDLE;
                        end
                     end
                     K_AHI: begin
                        next_addr_hi = byte_in;
                        next_kind    = K_ALO;
                     end
                     K_ALO: begin
                        next_addr = {addr_hi, byte_in};
                        next_kind = K_DATA;
                     end
                     K_DATA: begin
                        if (!i_write_protect && fifo_in_ready) begin
                           push      = 1'b1;
                           addr_inc  = 1'b1;
                           next_addr = addr + ADDR_STEP;
                        end else begin
                           next_state = S_IDLE;
                        end
                     end
                     default: next_state = S_IDLE;
                  endcase
               end
            end
         end
         S_SACK: begin
            if (scl_fall) begin
               if (!ack_on) begin
                  next_ack_on = 1'b1;
                  next_oe_n   = 1'b0;
               end else begin
                  next_ack_on = 1'b0;
                  next_oe_n   = 1'b1;
                  next_state  = after;
                  if (after == S_SEND) begin
                     next_sh   = rd_byte;
                     next_oe_n = rd_byte[7];
                     next_cnt  = '0;
                  end
               end
            end
         end
         S_SEND: begin
            if (scl_fall) begin
               if (cnt == LAST_BIT) begin
                  next_oe_n  = 1'b1;
                  next_state = S_MACK;
                  addr_inc   = 1'b1;
                  next_addr  = addr + ADDR_STEP;
               end else begin
                  next_cnt  = cnt + 3'h1;
                  next_sh   = {sh[6:0], 1'b0};
                  next_oe_n = sh[6];
               end
            end
         end
         S_MACK: begin
            if (scl_rise) begin
               if (!i_sda) begin
                  rd_req      = 1'b1;
                  next_ack_on = 1'b1;
               end else begin
                  next_state = S_IDLE;
               end
            end else if (scl_fall && ack_on) begin
               next_ack_on = 1'b0;
               next_sh     = rd_byte;
               next_oe_n   = rd_byte[7];
               next_cnt    = '0;
               next_state  = S_SEND;
            end
         end
         default: next_state = S_IDLE;
      endcase
      // start keeps the address latch, so random reads work
      if (start_c) begin
         next_state  = S_RECV;
         next_kind   = K_DEV;
         next_cnt    = '0;
         next_oe_n   = 1'b1;
         next_ack_on = 1'b0;
      end else if (stop_c) begin
         next_state  = S_IDLE;
         next_hs     = 1'b0;
         next_oe_n   = 1'b1;
         next_ack_on = 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         state   <= S_IDLE;
         after   <= S_RECV;
         kind    <= K_DEV;
         scl_q   <= 1'b1;
         sda_q   <= 1'b1;
         cnt     <= '0;
         sh      <= '0;
         addr_hi <= '0;
         addr    <= ADDR_RESET;
         hs      <= 1'b0;
         ack_on  <= 1'b0;
         oe_n    <= 1'b1;
      end else begin
         state   <= next_state;
         after   <= next_after;
         kind    <= next_kind;
         scl_q   <= i_scl;
         sda_q   <= i_sda;
         cnt     <= next_cnt;
         sh      <= next_sh;
         addr_hi <= next_addr_hi;
         addr    <= next_addr;
         hs      <= next_hs;
         ack_on  <= next_ack_on;
         oe_n    <= next_oe_n;
      end
   end

   // written bytes queue here and land in the array within a few cycles
   isp_fifo #(
      .WIDTH (FIFO_W),
      .DEPTH (FIFO_DEPTH)
   ) u_wr_fifo (
      .i_ref_clk (i_ref_clk),
      .i_srst    (i_srst),
      .i_valid   (push),
      .o_ready   (fifo_in_ready),
      .i_data    ({addr, byte_in}),
      .o_valid   (drain_valid),
      .i_ready   (drain_ready),
      .o_data    (drain_data)
   );

   // a read fetch owns the array port for its cycle
   assign drain_ready = ~rd_req;

   always_ff @(posedge i_ref_clk) begin
      if (drain_valid && drain_ready) begin
         mem[drain_data[FIFO_W-1:DATA_W]] <= drain_data[DATA_W-1:0];
      end
      if (i_srst) begin
         rd_byte <= '0;
      end else if (rd_req) begin
         rd_byte <= mem[addr];
      end
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);

   sequence byte_end_s;
      state == S_RECV && scl_rise && cnt == LAST_BIT;
   endsequence

   sequence send_end_s;
      state == S_SEND && scl_fall && cnt == LAST_BIT && !start_c && !stop_c;
   endsequence

   stop_leaves_hs_a: assert property (stop_c |=> !hs && state == S_IDLE)
      else $error("stop did not end high speed mode");

   stop_aborts_a: assert property (stop_c |=> o_sda_oe_n)
      else $error("bus still driven after stop");

   start_readies_a: assert property (
      start_c |=> state == S_RECV && kind == K_DEV && cnt == 3'h0)
      else $error("start did not prepare for a slave address");

   wp_refuse_a: assert property (
      byte_end_s ##0 (kind == K_DATA && i_write_protect && !stop_c)
      |=> state == S_IDLE && $stable(addr) && o_sda_oe_n)
      else $error("protected byte was accepted");

   miss_addr_a: assert property (
      byte_end_s ##0 (kind == K_DEV && !dev_hit && !start_c && !stop_c)
      |=> state == S_IDLE)
      else $error("foreign slave address answered");

   wrap_zero_a: assert property (
      addr_inc && addr == ADDR_TOP |=> addr == ADDR_RESET)
      else $error("address latch did not wrap");

   read_step_a: assert property (
      send_end_s |=> addr == $past(addr) + ADDR_STEP && state == S_MACK)
      else $error("read did not advance the address before the ack");

   commit_a: assert property (
      push |=> ##[0:2] (drain_valid && drain_ready))
      else $error("written byte not committed promptly");

   drive_edge_a: assert property (
      $fell(o_sda_oe_n) |-> $past(scl_fall))
      else $error("data line pulled outside a falling clock edge");

   nack_end_a: assert property (
      (state == S_MACK && scl_rise && i_sda && !start_c && !stop_c)
      |=> state == S_IDLE ##1 o_sda_oe_n)
      else $error("read continued after a missing acknowledge");
endmodule

/* File: hdl/isp_pkg.sv */
package isp_pkg;

   localparam int          ADDR_W      = 16;
   localparam int          DATA_W      = 8;
   localparam int          FIFO_W      = ADDR_W + DATA_W;
   localparam int          FIFO_DEPTH  = 8;
   localparam int          MEM_WORDS   = 65536;

   localparam logic [3:0]  DEV_TYPE    = 4'hA;
   localparam logic [4:0]  HS_CODE     = 5'h01;
   localparam logic [2:0]  LAST_BIT    = 3'h7;
   localparam logic [15:0] ADDR_RESET  = 16'h0000;
   localparam logic [15:0] ADDR_TOP    = 16'hFFFF;
   localparam logic [15:0] ADDR_STEP   = 16'h0001;

   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_RECV = 5'h02,
      S_SACK = 5'h04,
      S_SEND = 5'h08,
      S_MACK = 5'h10
   } isp_state_e;

   typedef enum logic [3:0] {
      K_DEV  = 4'h1,
      K_AHI  = 4'h2,
      K_ALO  = 4'h4,
      K_DATA = 4'h8
   } isp_kind_e;

endpackage
